// [rtl/ptf_fld.sv]
// fast link drop detector: window, criteria, wait timer
`timescale 1ns/10ps
`default_nettype none
module ptf_fld
    import ptf_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    // detector side
    ptf_fld_if.det    fld
);
    localparam int WAIT_LIM = MAX_WAIT_CYC + 1;

    typedef struct packed {
        logic [4:0] step;
        logic [4:0] us;
        logic [4:0] seen;
        logic [4:0] hit;
        logic       waiting;
        logic [7:0] wait_cnt;
        logic       drop;
    } ptf_fld_st_t;

    localparam ptf_fld_st_t ST_RST = '0;

    ptf_fld_st_t st_ff;
    ptf_fld_st_t nxt_st;

    if (WIN_STEP_CYC < 1 || WIN_STEP_CYC > 32 || MAX_WAIT_CYC > 255)
        $error("ptf_fld: timing constants out of range");

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.hit  = '0;
        nxt_st.drop = 1'b0;
        // each criterion is collected on its own
        nxt_st.seen = st_ff.seen | (fld.crit_evt & fld.crit_en);
        if (st_ff.step == 5'(WIN_STEP_CYC - 1))
        begin
            nxt_st.step = '0;
            // window closes after win_len + 1 microsteps
            if (st_ff.us >= fld.win_len)
            begin
                nxt_st.us   = '0;
                nxt_st.hit  = nxt_st.seen;
                nxt_st.seen = '0;
            end
            else
            begin
                nxt_st.us = st_ff.us + 5'd1;
            end
        end
        else
        begin
            nxt_st.step = st_ff.step + 5'd1;
        end
        if (st_ff.hit != '0 && fld.bypass)
        begin
            // no waiting when the longest wait is skipped
            nxt_st.drop    = 1'b1;
            nxt_st.waiting = 1'b0;
        end
        else if (st_ff.hit != '0 && !st_ff.waiting)
        begin
            nxt_st.waiting  = 1'b1;
            nxt_st.wait_cnt = '0;
        end
        else if (st_ff.waiting)
        begin
            if (st_ff.wait_cnt == 8'(MAX_WAIT_CYC - 1))
            begin
                nxt_st.waiting = 1'b0;
                nxt_st.drop    = 1'b1;
            end
            else
            begin
                nxt_st.wait_cnt = st_ff.wait_cnt + 8'd1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    assign fld.hit      = st_ff.hit;
    assign fld.drop_req = st_ff.drop;

    sequence s_hit_now;
        st_ff.hit != '0;
    endsequence

    a_bypass_drop_fast: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_hit_now and fld.bypass |=> fld.drop_req)
        else $error("bypassed drop not raised next cycle");

    a_wait_then_drop: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_hit_now and !fld.bypass and !st_ff.waiting
        |=> !fld.drop_req ##[1:WAIT_LIM] fld.drop_req)
        else $error("drop after wait not raised in time");

    a_hit_enabled_only: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (fld.crit_en == '0 && $past(fld.crit_en) == '0
         && st_ff.seen == '0) |=> st_ff.hit == '0)
        else $error("hit from a disabled criterion");
endmodule : ptf_fld
`default_nettype wire

// [rtl/ptf_fld_if.sv]
// signals between the register block and the fast drop detector
`timescale 1ns/10ps
`default_nettype none
interface ptf_fld_if;
    logic [4:0] crit_en;
    logic [4:0] crit_evt;
    logic [4:0] win_len;
    logic       bypass;
    logic [4:0] hit;
    logic       drop_req;
    modport ctl (output crit_en, crit_evt, win_len, bypass,
                 input  hit, drop_req);
    modport det (input  crit_en, crit_evt, win_len, bypass,
                 output hit, drop_req);
endinterface : ptf_fld_if
`default_nettype wire

// [rtl/ptf_pkg.sv]
// constants for the phy test pattern and fast link drop block
package ptf_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 16;
    localparam int          N_CRIT        = 5;
    localparam logic [7:0]  ADR_TEST      = 8'h25;
    localparam logic [7:0]  ADR_TIMERS    = 8'h2c;
    localparam logic [7:0]  ADR_FLD       = 8'h2d;
    localparam logic [15:0] RST_TEST      = 16'h0480;
    localparam logic [15:0] RST_TIMERS    = 16'h141f;
    localparam logic [15:0] RST_FLD       = 16'h0000;
    localparam logic [15:0] WMASK_TEST    = 16'h0fff;
    localparam logic [15:0] WMASK_TIMERS  = 16'h3fff;
    localparam logic [15:0] WMASK_FLD     = 16'hc01f;
    // test_pattern_control fields
    localparam int          TST_CODE_LO   = 0;
    localparam int          TST_10BT_EN   = 4;
    localparam int          TST_CH_LO     = 5;
    localparam int          TST_CH_ALL    = 7;
    localparam int          TST_EXT_EN    = 8;
    localparam int          TST_EXT_MSB   = 9;
    localparam logic [3:0]  TST_CODE_MAX  = 4'hd;
    // crossover_and_window_timers fields
    localparam int          TMR_ROB_LO    = 0;
    localparam int          TMR_FAST_LO   = 4;
    localparam int          TMR_WIN_LO    = 9;
    // fast_drop_config_status fields
    localparam int          FLD_MODE_LO   = 0;
    localparam int          FLD_STAT_LO   = 8;
    localparam int          FLD_STUCK     = 13;
    localparam int          FLD_BYPASS    = 14;
    localparam int          FLD_FORCE     = 15;
    // timing
    localparam int          CLK_MHZ       = 20;
    localparam int          WIN_STEP_NS   = 1000;
    localparam int          WIN_STEP_CYC  = WIN_STEP_NS * CLK_MHZ / 1000;
    localparam int          MAX_WAIT_NS   = 10000;
    localparam int          MAX_WAIT_CYC  = MAX_WAIT_NS * CLK_MHZ / 1000;
    localparam int          FAST_STEP_US  = 4000;
    localparam int          FAST_STEP_CYC = FAST_STEP_US * CLK_MHZ;
    localparam int          ROB_FULL_US   = 500000;
    localparam int          ROB_RST_VAL   = 15;
    localparam int          ROB_STEP_CYC  = ROB_FULL_US * CLK_MHZ / ROB_RST_VAL;
endpackage : ptf_pkg

// [rtl/ptf_top.sv]
// test pattern, crossover timer and fast link drop registers
`timescale 1ns/10ps
`default_nettype none
module ptf_top
    import ptf_pkg::*;
#(
    parameter int FAST_STEP = FAST_STEP_CYC,
    parameter int ROB_STEP  = ROB_STEP_CYC
)(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    // phy status
    input  wire logic [4:0]        crit_evt_i,
    input  wire logic              rx_signal_i,
    input  wire logic              slicer_stuck_i,
    input  wire logic              link_up_i,
    input  wire logic              xover_fast_mode_i,
    input  wire logic              xover_robust_mode_i,
    // test pattern controls
    output logic                   test_10bt_en_o,
    output logic [3:0]             test_pattern_code_o,
    output logic                   ext_pattern_fast_enable_o,
    output logic                   ext_pattern_bit_o,
    output logic [3:0]             test_channel_en_o,
    // link controls
    output logic                   mdix_swap_o,
    output logic                   link_drop_o
);
    typedef struct packed {
        logic [15:0] test;
        logic [15:0] tmr;
        logic [15:0] cfg;
        logic [4:0]  stat;
        logic [15:0] rdata;
        logic [4:0]  ext_pos;
        logic        ext_bit;
        logic [3:0]  ch_en;
        logic [19:0] xs_step;
        logic [4:0]  xs_units;
        logic        swap;
        logic        drop;
    } ptf_top_st_t;

    localparam ptf_top_st_t ST_RST = '{
        test: RST_TEST, tmr: RST_TIMERS, cfg: RST_FLD, default: '0};

    ptf_top_st_t st_ff;
    ptf_top_st_t nxt_st;
    ptf_fld_if   fld_bus ();

    logic        ext_on;
    logic [4:0]  ext_run;
    logic [19:0] xs_lim;
    logic [4:0]  xs_val;
    logic        xs_run;
    logic        test_on;

    if (FAST_STEP < 1 || FAST_STEP > 1048576 || ROB_STEP < 1
        || ROB_STEP > 1048576)
        $error("ptf_top: crossover step counts out of range");

    ptf_fld u_fld (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .fld        (fld_bus.det)
    );

    assign fld_bus.crit_en  = st_ff.cfg[FLD_MODE_LO +: 5];
    assign fld_bus.crit_evt = crit_evt_i;
    assign fld_bus.win_len  = st_ff.tmr[TMR_WIN_LO +: 5];
    assign fld_bus.bypass   = st_ff.cfg[FLD_BYPASS];

    // extended pattern only without the 10BASE-T enable
    assign ext_on  = st_ff.test[TST_EXT_EN] && !st_ff.test[TST_10BT_EN];
    assign ext_run = {st_ff.test[TST_EXT_MSB], st_ff.test[3:0]};
    assign test_on = ext_on || st_ff.test[TST_10BT_EN];
    assign xs_run  = !link_up_i && (xover_fast_mode_i
                     || xover_robust_mode_i);
    assign xs_lim  = xover_fast_mode_i ? 20'(FAST_STEP - 1)
                                       : 20'(ROB_STEP - 1);
    assign xs_val  = xover_fast_mode_i ? st_ff.tmr[TMR_FAST_LO +: 5]
                   : {1'b0, st_ff.tmr[TMR_ROB_LO +: 4]};

    always_comb
    begin
        nxt_st = st_ff;
        // writes, reserved bits masked
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ADR_TEST:
                    nxt_st.test = reg_wdata_i & WMASK_TEST;
                ADR_TIMERS:
                    nxt_st.tmr = reg_wdata_i & WMASK_TIMERS;
                ADR_FLD:
                    nxt_st.cfg = reg_wdata_i & WMASK_FLD;
                default:
                    nxt_st.cfg = st_ff.cfg;
            endcase
        end
        // reads, unmapped gives zero
        nxt_st.rdata = '0;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                ADR_TEST:
                    nxt_st.rdata = st_ff.test;
                ADR_TIMERS:
                    nxt_st.rdata = st_ff.tmr;
                ADR_FLD:
                begin
                    nxt_st.rdata = st_ff.cfg;
                    nxt_st.rdata[FLD_STUCK] = slicer_stuck_i;
                    nxt_st.rdata[FLD_STAT_LO +: 5] = st_ff.stat;
                end
                default:
                    nxt_st.rdata = '0;
            endcase
        end
        // status: clear on read, a new event wins
        if (reg_rd_i && reg_addr_i == ADR_FLD)
            nxt_st.stat = '0;
        nxt_st.stat = nxt_st.stat | fld_bus.hit;
        // one followed by ext_run zeros, zero run clears
        if (!ext_on || ext_run == '0)
        begin
            nxt_st.ext_pos = '0;
            nxt_st.ext_bit = 1'b0;
        end
        else
        begin
            nxt_st.ext_bit = (st_ff.ext_pos == '0);
            if (st_ff.ext_pos >= ext_run)
                nxt_st.ext_pos = '0;
            else
                nxt_st.ext_pos = st_ff.ext_pos + 5'd1;
        end
        // channel routing
        if (!test_on)
            nxt_st.ch_en = '0;
        else if (st_ff.test[TST_CH_ALL])
            nxt_st.ch_en = 4'hf;
        else
            nxt_st.ch_en = 4'h1 << st_ff.test[TST_CH_LO +: 2];
        // crossover pair swap timer
        if (!xs_run)
        begin
            nxt_st.xs_step  = '0;
            nxt_st.xs_units = '0;
        end
        else if (st_ff.xs_step >= xs_lim)
        begin
            nxt_st.xs_step = '0;
            if (st_ff.xs_units + 5'd1 >= xs_val)
            begin
                nxt_st.xs_units = '0;
                nxt_st.swap     = !st_ff.swap;
            end
            else
            begin
                nxt_st.xs_units = st_ff.xs_units + 5'd1;
            end
        end
        else
        begin
            nxt_st.xs_step = st_ff.xs_step + 20'd1;
        end
        // link drop: forced on no signal, or detector request
        nxt_st.drop = (st_ff.cfg[FLD_FORCE] && !rx_signal_i)
                      || fld_bus.drop_req;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata_o               = st_ff.rdata;
    assign test_10bt_en_o            = st_ff.test[TST_10BT_EN];
    assign test_pattern_code_o       = st_ff.test[TST_CODE_LO +: 4];
    assign ext_pattern_fast_enable_o = ext_on;
    assign ext_pattern_bit_o         = st_ff.ext_bit;
    assign test_channel_en_o         = st_ff.ch_en;
    assign mdix_swap_o               = st_ff.swap;
    assign link_drop_o               = st_ff.drop;

    sequence s_fld_read;
        reg_rd_i && reg_addr_i == ADR_FLD;
    endsequence

    sequence s_one_zero_one;
        ext_pattern_bit_o ##1 !ext_pattern_bit_o ##1 ext_pattern_bit_o;
    endsequence

    a_status_clear_read: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_fld_read and fld_bus.hit == '0 |=> st_ff.stat == '0)
        else $error("status not cleared by read");

    a_status_latch_hit: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        fld_bus.hit != '0 |=> (st_ff.stat & $past(fld_bus.hit))
                              == $past(fld_bus.hit))
        else $error("status bit not latched");

    a_status_read_value: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_fld_read |=> reg_rdata_o[12:8] == $past(st_ff.stat))
        else $error("status read value wrong");

    a_ext_zero_clear: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        ext_run == '0 |=> !ext_pattern_bit_o)
        else $error("zero run did not clear pattern");

    a_ext_run_one: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (ext_on && ext_run == 5'd1 && !reg_wr_i)[*3] ##0
        ext_pattern_bit_o |-> s_one_zero_one)
        else $error("one zero between ones expected");

    a_chan_all: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        test_on && st_ff.test[TST_CH_ALL] |=> test_channel_en_o == 4'hf)
        else $error("all channels not driven");

    a_force_drop: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        st_ff.cfg[FLD_FORCE] && !rx_signal_i |=> link_drop_o)
        else $error("forced drop missing");

    a_reserved_read: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        reg_rd_i && reg_addr_i == ADR_TEST |=> reg_rdata_o[15:12] == '0)
        else $error("reserved bits not zero");

    a_stuck_read: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_fld_read |=> reg_rdata_o[FLD_STUCK] == $past(slicer_stuck_i))
        else $error("slicer stuck bit wrong");

    a_swap_idle_hold: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !xs_run |=> $stable(mdix_swap_o))
        else $error("pair swap moved while timer idle");

    a_chan_single: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        test_on && !st_ff.test[TST_CH_ALL] |=> $onehot(test_channel_en_o))
        else $error("single channel not one-hot");

    a_chan_off: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !test_on |=> test_channel_en_o == '0)
        else $error("channel driven without test");

    a_write_masked: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == ADR_FLD
        |=> st_ff.cfg == ($past(reg_wdata_i) & WMASK_FLD))
        else $error("reserved config bits written");

    a_det_drop_pass: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        fld_bus.drop_req |=> link_drop_o)
        else $error("detector drop not passed on");

    a_test_code_out: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == ADR_TEST
        |=> test_pattern_code_o == $past(reg_wdata_i[TST_CODE_LO +: 4]))
        else $error("pattern code output wrong");

    a_tenbt_enable_out: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == ADR_TEST
        |=> test_10bt_en_o == $past(reg_wdata_i[TST_10BT_EN]))
        else $error("10BASE-T enable output wrong");
endmodule : ptf_top
`default_nettype wire

// [tb/ptf_peer.sv]
// far end phy model: line signal, link state and criterion events
`timescale 1ns/10ps
`default_nettype none
module ptf_peer
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    // bench commands
    input  wire logic       talk_i,
    input  wire logic [4:0] evt_i,
    // phy side
    input  wire logic       link_drop_i,
    output logic            rx_signal_o,
    output logic            link_up_o,
    output logic [4:0]      crit_evt_o
);
    // link held only while the far end talks and no drop is asked
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            link_up_o <= 1'b0;
        else
            link_up_o <= talk_i & !link_drop_i;
    end
    assign rx_signal_o = talk_i;
    assign crit_evt_o  = evt_i;
endmodule : ptf_peer
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the test pattern and fast drop registers
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ptf_pkg::*;
;
    logic              core_clk_i = 1'b0;
    logic              arst_n_i   = 1'b0;
    logic [ADDR_W-1:0] addr       = '0;
    logic [DATA_W-1:0] wdata      = '0;
    logic              wr         = 1'b0;
    logic              rd         = 1'b0;
    logic [4:0]        evt        = '0;
    logic              talk       = 1'b1;
    logic              stuck      = 1'b0;
    logic              fastm      = 1'b0;
    logic              robm       = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              rx_sig, lnk_up, ten, extb, swap, drop, exten;
    logic [4:0]        crit;
    logic [3:0]        code, chan;
    int                errors    = 0;
    int                cmp_count = 0;
    int                shadow[int];
    int                stat      = 0;
    int                n;
    int                runs[5]   = '{1, 3, 17, 31, 0};

    always #25 core_clk_i = ~core_clk_i;

    ptf_top #(.FAST_STEP(4), .ROB_STEP(6)) ptf_top_i (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .crit_evt_i(crit),
        .rx_signal_i(rx_sig), .slicer_stuck_i(stuck),
        .link_up_i(lnk_up), .xover_fast_mode_i(fastm),
        .xover_robust_mode_i(robm), .test_10bt_en_o(ten),
        .test_pattern_code_o(code), .ext_pattern_fast_enable_o(exten),
        .ext_pattern_bit_o(extb), .test_channel_en_o(chan),
        .mdix_swap_o(swap), .link_drop_o(drop));

    ptf_peer ptf_peer_i (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .talk_i(talk),
        .evt_i(evt), .link_drop_i(drop), .rx_signal_o(rx_sig),
        .link_up_o(lnk_up), .crit_evt_o(crit));

    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic chk_rng(input int g, input int lo, input int hi);
        cmp_count++;
        if (g < lo || g > hi)
        begin
            errors++;
            $display("wrong value at %0t got %h exp %h", $time, g, lo);
        end
    endtask : chk_rng

    function automatic logic [15:0] msk(input logic [7:0] a);
        case (a)
            ADR_TEST:   return WMASK_TEST;
            ADR_TIMERS: return WMASK_TIMERS;
            ADR_FLD:    return WMASK_FLD;
            default:    return 16'h0000;
        endcase
    endfunction : msk

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
        if (shadow.exists(a))
            shadow[a] = int'(d & msk(a));
        repeat (2) @(negedge core_clk_i);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a);
        logic [15:0] e;
        @(posedge core_clk_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        e = shadow.exists(a) ? 16'(shadow[a]) : 16'h0000;
        if (a == ADR_FLD)
            e = e | 16'(stuck) << 13 | 16'(stat) << 8;
        @(negedge core_clk_i);
        chk(rdata, e);
        if (a == ADR_FLD)
            stat = 0;
    endtask : rd_chk

    task automatic pulse(input logic [4:0] e);
        @(posedge core_clk_i);
        evt <= e;
        @(posedge core_clk_i);
        evt <= 5'h00;
        stat = stat | (int'(e) & shadow[ADR_FLD] & 31);
    endtask : pulse

    // cycles until a drop pulse, or until the swap state changes
    task automatic await(input bit sw, output int c);
        logic s0;
        c  = 0;
        s0 = swap;
        do
        begin
            @(negedge core_clk_i);
            c++;
            if (c > 2000)
            begin
                errors++;
                conclude();
            end
        end
        while (sw ? swap === s0 : drop !== 1'b1);
    endtask : await

    initial
    begin
        n = $urandom(32'h45795bec);
        shadow[ADR_TEST]   = 'h0480;
        shadow[ADR_TIMERS] = 'h141f;
        shadow[ADR_FLD]    = 'h0000;
        repeat (12) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        rd_chk(ADR_TEST);
        rd_chk(ADR_TIMERS);
        rd_chk(ADR_FLD);
        wr_reg(8'h30, 16'hffff);
        rd_chk(8'h30);
        for (int i = 0; i < 12; i++)
        begin
            n = i % 3 == 0 ? ADR_TEST : i % 3 == 1 ? ADR_TIMERS : ADR_FLD;
            wr_reg(8'(n), 16'h0000);
            wr_reg(8'(n), 16'($urandom));
            rd_chk(8'(n));
        end
        for (int c = 0; c < 14; c++)
        begin
            wr_reg(ADR_TEST, 16'h0000);
            wr_reg(ADR_TEST, 16'(16 + c));
            chk({11'h000, ten, code}, 16'(16 + c));
        end
        for (int s = 0; s < 8; s++)
        begin
            wr_reg(ADR_TEST, 16'h0000);
            wr_reg(ADR_TEST, 16'(s << 5 | 16));
            chk(16'(chan), s > 3 ? 16'h000f : 16'(1 << s));
        end
        wr_reg(ADR_TEST, 16'h0000);
        wr_reg(ADR_TEST, 16'h0113);
        chk(16'(exten), 16'h0000);
        wr_reg(8'h00, 16'h2000);
        rd_chk(8'h00);
        foreach (runs[k])
        begin
            wr_reg(ADR_TEST, 16'h0000);
            wr_reg(ADR_TEST, 16'('h100 | runs[k] & 15
                                  | runs[k] >> 4 << 9));
            chk(16'(exten), 16'h0001);
            n = 0;
            repeat (2 * (runs[k] + 1))
            begin
                @(negedge core_clk_i);
                n += int'(extb === 1'b1);
            end
            chk(16'(n), runs[k] > 0 ? 16'h0002 : 16'h0000);
        end
        // one window step, bypass on for each criterion alone and for all five, disabled events, then bypass off
        wr_reg(ADR_TIMERS, 16'h0000);
        for (int b = 0; b < 6; b++)
        begin
            wr_reg(ADR_FLD, b < 5 ? 16'(16'h4000 | 1 << b) : 16'h401f);
            pulse(b < 5 ? 5'(1 << b) : 5'h0a);
            await(1'b0, n);
            chk_rng(n, 1, 24);
            rd_chk(ADR_FLD);
            rd_chk(ADR_FLD);
        end
        wr_reg(ADR_FLD, 16'h4001);
        pulse(5'h1e);
        n = 0;
        repeat (60)
        begin
            @(negedge core_clk_i);
            n += int'(drop === 1'b1);
        end
        chk(16'(n), 16'h0000);
        rd_chk(ADR_FLD);
        wr_reg(ADR_FLD, 16'h0001);
        pulse(5'h01);
        await(1'b0, n);
        chk_rng(n, 200, 260);
        rd_chk(ADR_FLD);
        // five window steps, second event right after a drop
        wr_reg(ADR_TIMERS, 16'h0800);
        wr_reg(ADR_FLD, 16'h4004);
        pulse(5'h04);
        await(1'b0, n);
        pulse(5'h04);
        await(1'b0, n);
        chk_rng(n, 94, 102);
        rd_chk(ADR_FLD);
        @(posedge core_clk_i);
        stuck <= 1'b1;
        rd_chk(ADR_FLD);
        @(posedge core_clk_i);
        stuck <= 1'b0;
        wr_reg(ADR_FLD, 16'h8000);
        chk(16'(drop), 16'h0000);
        @(posedge core_clk_i);
        talk <= 1'b0;
        @(posedge core_clk_i);
        repeat (4) @(negedge core_clk_i);
        chk(16'(drop), 16'h0001);
        // crossover with link down: quick 2 units, robust 3 units
        wr_reg(ADR_FLD, 16'h0000);
        wr_reg(ADR_TIMERS, 16'h0023);
        @(posedge core_clk_i);
        fastm <= 1'b1;
        await(1'b1, n);
        await(1'b1, n);
        chk_rng(n, 7, 9);
        @(posedge core_clk_i);
        fastm <= 1'b0;
        robm  <= 1'b1;
        await(1'b1, n);
        await(1'b1, n);
        chk_rng(n, 17, 19);
        conclude();
    end
endmodule : testbench
`default_nettype wire
